// ### hw/cca_pkg.sv
// Package of the channel-change arrival timer ends.
// Assumes a 50 MHz system clock on both ends.
package cca_pkg;
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          MS_CYC        = CLK_HZ / 1000;
  localparam int          DEF_JUMP_MS   = 1300;
  localparam int          ALLOW_MIN_MS  = 20;
  localparam int          ALLOW_MAX_MS  = 40;
  localparam int          TXN_BOUND_MS  = 4000;
  localparam int          DIRECT_MS     = 1000;
  localparam int          ABORT_RACE_MS = 1200;
  localparam int          RNG_INT_RST   = 1000;
  localparam int          ALLOW_RST     = 40;
  // Register byte offsets
  localparam logic [11:0] OFF_CMD       = 12'h000;
  localparam logic [11:0] OFF_RNG_INT   = 12'h004;
  localparam logic [11:0] OFF_ALLOW     = 12'h008;
  localparam logic [11:0] OFF_STATUS    = 12'h00C;
  localparam logic [11:0] OFF_HOLD      = 12'h010;
  localparam logic [11:0] OFF_INT_STAT  = 12'h014;
  localparam logic [11:0] OFF_INT_MASK  = 12'h018;
  // Command word fields
  localparam int          CMD_GO_BIT    = 0;
  localparam int          CMD_TECH_LSB  = 4;
  localparam int          CMD_HINT_BIT  = 8;
  localparam int          CMD_CRCE_BIT  = 9;
  // Interrupt bits
  localparam int          IRQ_ARRIVED   = 0;
  localparam int          IRQ_EXPIRED   = 1;
  localparam int          IRQ_ABORTED   = 2;
  localparam int          IRQ_CRC_DROP  = 3;
  localparam int          IRQ_LATE      = 4;
  localparam int          IRQ_W         = 5;
  // Initialization technique codes
  localparam logic [2:0]  TECH_RESET    = 3'h0;
  localparam logic [2:0]  TECH_MAINT    = 3'h2;
  localparam logic [2:0]  TECH_DIRECT   = 3'h4;
endpackage : cca_pkg

// ### hw/cca_link_if.sv
// Link carrying channel-change messages between head-end and modem.
// Both ends share clk_sys; bench joins the two modports.
`timescale 1ns/10ps
`default_nettype none
interface cca_link_if;
  logic        req_vld;
  logic [2:0]  req_tech;
  logic        req_hints;
  logic        ack_vld;
  logic        he_crc_ok;
  logic        sched;
  logic        rsp_vld;
  logic        rsp_arrive;
  logic        rsp_jump_vld;
  logic [15:0] rsp_jump_ms;
  logic        rng_req;
  logic        cm_crc_ok;
  modport headend (output req_vld, req_tech, req_hints, ack_vld,
                   he_crc_ok, sched,
                   input  rsp_vld, rsp_arrive, rsp_jump_vld, rsp_jump_ms,
                   rng_req, cm_crc_ok);
  modport modem   (input  req_vld, req_tech, req_hints, ack_vld,
                   he_crc_ok, sched,
                   output rsp_vld, rsp_arrive, rsp_jump_vld, rsp_jump_ms,
                   rng_req, cm_crc_ok);
endinterface : cca_link_if
`default_nettype wire

// ### hw/cca_modem.sv
// Modem end: answers change requests, jumps, ranges and arrives.
// Assumes link messages synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module cca_modem
  import cca_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  cca_link_if.modem        link,
  input  wire logic [15:0] jump_ms,
  input  wire logic        jump_en,
  input  wire logic        crc_err_inj,
  output logic             moving,
  output logic             arrived,
  output logic [2:0]       tech_seen,
  output logic             slow
);
  typedef enum logic [2:0] {
    CM_IDLE   = 3'b000,
    CM_JUMP   = 3'b001,
    CM_WAIT   = 3'b010,
    CM_ARRIVE = 3'b011
  } cca_cm_st_t;

  typedef struct packed {
    cca_cm_st_t  st;
    logic [15:0] tick;
    logic [15:0] ms;
    logic [2:0]  tech;
    logic        hints;
    logic        rsp_vld;
    logic        rsp_arrive;
    logic        rsp_jump_vld;
    logic [15:0] rsp_jump_ms;
    logic        rng_req;
    logic        crc_ok;
    logic        arrived;
    logic        slow;
    logic        moving;
  } cca_cm_t;

  cca_cm_t s_r;
  cca_cm_t s_nxt;
  logic    ms_tick;
  logic    req_ok;

  assign ms_tick = (s_r.tick == 16'(MS_CYCLES - 1));
  assign req_ok  = link.req_vld && link.he_crc_ok;

  always_comb begin
    s_nxt              = s_r;
    s_nxt.rsp_vld      = 1'b0;
    s_nxt.rng_req      = 1'b0;
    s_nxt.arrived      = 1'b0;
    s_nxt.crc_ok       = !crc_err_inj;
    s_nxt.tick         = ms_tick ? 16'h0000 : s_r.tick + 16'h0001;
    if (ms_tick && s_r.st != CM_IDLE) begin
      s_nxt.ms = s_r.ms + 16'h0001;
    end
    case (s_r.st)
      CM_IDLE: begin
        if (req_ok) begin
          s_nxt.tech         = link.req_tech;
          s_nxt.hints        = link.req_hints;
          s_nxt.rsp_vld      = 1'b1;
          s_nxt.rsp_arrive   = 1'b0;
          s_nxt.rsp_jump_vld = jump_en;
          s_nxt.rsp_jump_ms  = jump_ms;
          s_nxt.ms           = 16'h0000;
          s_nxt.slow         = 1'b0;
          s_nxt.st = (link.req_tech == TECH_RESET) ? CM_IDLE : CM_JUMP;
        end
      end
      CM_JUMP: begin
        if (s_r.ms >= jump_ms) begin
          s_nxt.st = (s_r.tech == TECH_DIRECT) ? CM_ARRIVE : CM_WAIT;
        end
      end
      CM_WAIT: begin
        if (link.sched) begin
          s_nxt.rng_req = 1'b1;
          s_nxt.st      = CM_ARRIVE;
        end
      end
      CM_ARRIVE: begin
        s_nxt.rsp_vld      = 1'b1;
        s_nxt.rsp_arrive   = 1'b1;
        s_nxt.rsp_jump_vld = 1'b0;
        s_nxt.arrived      = 1'b1;
        s_nxt.slow = (s_r.tech == TECH_DIRECT)
                     && (s_r.ms > 16'(DIRECT_MS));
        s_nxt.st           = CM_IDLE;
      end
      default: s_nxt.st = CM_IDLE;
    endcase
    s_nxt.moving = (s_nxt.st != CM_IDLE);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{st: CM_IDLE, crc_ok: 1'b1, default: '0};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign link.rsp_vld      = s_r.rsp_vld;
  assign link.rsp_arrive   = s_r.rsp_arrive;
  assign link.rsp_jump_vld = s_r.rsp_jump_vld;
  assign link.rsp_jump_ms  = s_r.rsp_jump_ms;
  assign link.rng_req      = s_r.rng_req;
  assign link.cm_crc_ok    = s_r.crc_ok;
  assign moving            = s_r.moving;
  assign arrived           = s_r.arrived;
  assign tech_seen         = s_r.tech;
  assign slow              = s_r.slow;
endmodule : cca_modem
`default_nettype wire

// ### hw/cca_headend.sv
// Destination head-end: issues change requests, runs the hold timer.
// Assumes an APB master on clk_sys and a modem on the link.
// Function
// - Hold timer is jump time plus allowance
// - Absent jump element means 1300 ms jump
// - Allowance: twice ranging interval plus 20-40 ms
// - Technique 4 means use channels directly
// - Technique 2 means station maintenance first
// - Maintenance: schedule modem right after request
// - Modem maintains without waiting for sync
// - Direct use should finish within 1 s
// - Lost depart: old-end abort releases resources
// - Discard messages with failed CRC
// - Transaction should finish within four seconds
// - MAC reset not tracked; stray events ignored
// - Ranging or bandwidth request proves arrival
// - Hold timer expiry releases reserved resources
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module cca_headend
  import cca_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  cca_link_if.headend      link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        old_abort,
  output logic             resv_held,
  output logic             irq
);
  typedef enum logic [1:0] {
    HE_IDLE = 2'b00,
    HE_HOLD = 2'b01,
    HE_DONE = 2'b10
  } cca_he_st_t;

  typedef struct packed {
    cca_he_st_t         st;
    logic [15:0]        tick;
    logic [19:0]        hold_ms;
    logic [15:0]        elapsed;
    logic [15:0]        jump_used;
    logic [2:0]         tech;
    logic               req_vld;
    logic               hints;
    logic               ack_vld;
    logic               crc_ok;
    logic               crc_err;
    logic               sched;
    logic [15:0]        rng_int;
    logic [5:0]         allow;
    logic [IRQ_W-1:0]   int_stat;
    logic [IRQ_W-1:0]   int_mask;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               irq;
    logic               held;
  } cca_he_t;

  cca_he_t          s_r;
  cca_he_t          s_nxt;
  logic             ms_tick;
  logic             setup;
  logic             wr;
  logic             arrive_ev;
  logic             depart_ok;
  logic [IRQ_W-1:0] ev;
  logic [19:0]      allowance;

  assign ms_tick   = (s_r.tick == 16'(MS_CYCLES - 1));
  assign setup     = psel && !penable;
  assign wr        = psel && penable && pwrite && s_r.pready;
  // Receipt allowance from the current interval and margin
  assign allowance = {3'b000, s_r.rng_int, 1'b0}
                     + {14'h0000, s_r.allow};
  // Arrival evidence on the new channel, good CRC only
  assign arrive_ev = link.cm_crc_ok
                     && ((link.rsp_vld && link.rsp_arrive)
                         || link.rng_req);
  assign depart_ok = link.cm_crc_ok && link.rsp_vld && !link.rsp_arrive;

  always_comb begin
    s_nxt         = s_r;
    ev            = '0;
    s_nxt.req_vld = 1'b0;
    s_nxt.ack_vld = 1'b0;
    s_nxt.tick    = ms_tick ? 16'h0000 : s_r.tick + 16'h0001;
    if ((link.rsp_vld || link.rng_req) && !link.cm_crc_ok) begin
      ev[IRQ_CRC_DROP] = 1'b1;
    end
    case (s_r.st)
      HE_IDLE: begin
        s_nxt.sched = 1'b0;
      end
      HE_HOLD: begin
        if (ms_tick) begin
          s_nxt.elapsed = s_r.elapsed + 16'h0001;
          if (s_r.hold_ms != 20'h00000) begin
            s_nxt.hold_ms = s_r.hold_ms - 20'h00001;
          end
          if (s_r.elapsed == 16'(TXN_BOUND_MS - 1)) begin
            ev[IRQ_LATE] = 1'b1;
          end
        end
        if (depart_ok && link.rsp_jump_vld) begin
          s_nxt.jump_used = link.rsp_jump_ms;
          s_nxt.hold_ms = {4'h0, link.rsp_jump_ms} + allowance;
        end
        if (arrive_ev) begin
          s_nxt.ack_vld   = 1'b1;
          s_nxt.sched     = 1'b0;
          s_nxt.st        = HE_DONE;
          ev[IRQ_ARRIVED] = 1'b1;
        end else if (old_abort) begin
          s_nxt.sched     = 1'b0;
          s_nxt.st        = HE_DONE;
          ev[IRQ_ABORTED] = 1'b1;
        end else if (s_r.hold_ms == 20'h00000) begin
          s_nxt.sched     = 1'b0;
          s_nxt.st        = HE_DONE;
          ev[IRQ_EXPIRED] = 1'b1;
        end
      end
      HE_DONE: begin
        s_nxt.st = HE_IDLE;
      end
      default: s_nxt.st = HE_IDLE;
    endcase
    // Register writes
    if (wr) begin
      case (paddr)
        OFF_CMD: begin
          if (pwdata[CMD_GO_BIT] && s_r.st == HE_IDLE) begin
            s_nxt.req_vld   = 1'b1;
            s_nxt.tech      = pwdata[CMD_TECH_LSB +: 3];
            s_nxt.hints     = pwdata[CMD_HINT_BIT];
            s_nxt.crc_err   = pwdata[CMD_CRCE_BIT];
            s_nxt.jump_used = 16'(DEF_JUMP_MS);
            s_nxt.hold_ms   = 20'(DEF_JUMP_MS) + allowance;
            s_nxt.elapsed   = 16'h0000;
            // MAC reset changes are not tracked here
            s_nxt.st = (pwdata[CMD_TECH_LSB +: 3] == TECH_RESET)
                       ? HE_IDLE : HE_HOLD;
            s_nxt.sched = (pwdata[CMD_TECH_LSB +: 3] == TECH_MAINT)
                          && !pwdata[CMD_CRCE_BIT];
          end
        end
        OFF_RNG_INT: s_nxt.rng_int = pwdata[15:0];
        OFF_ALLOW: begin
          if (pwdata < 32'(ALLOW_MIN_MS)) begin
            s_nxt.allow = 6'(ALLOW_MIN_MS);
          end else if (pwdata > 32'(ALLOW_MAX_MS)) begin
            s_nxt.allow = 6'(ALLOW_MAX_MS);
          end else begin
            s_nxt.allow = pwdata[5:0];
          end
        end
        OFF_INT_MASK: s_nxt.int_mask = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // Sticky status: a new event wins over a clear
    if (wr && paddr == OFF_INT_STAT) begin
      s_nxt.int_stat = (s_r.int_stat & ~pwdata[IRQ_W-1:0]) | ev;
    end else begin
      s_nxt.int_stat = s_r.int_stat | ev;
    end
    s_nxt.crc_ok = !(s_nxt.req_vld && s_nxt.crc_err);
    s_nxt.irq    = |(s_nxt.int_stat & s_nxt.int_mask);
    s_nxt.held   = (s_nxt.st == HE_HOLD);
    // APB answer, one access cycle per transfer
    s_nxt.pready  = setup;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata  = 32'h00000000;
    if (setup) begin
      case (paddr)
        OFF_CMD: begin
          s_nxt.prdata[CMD_TECH_LSB +: 3] = s_r.tech;
          s_nxt.prdata[CMD_HINT_BIT]      = s_r.hints;
        end
        OFF_RNG_INT:  s_nxt.prdata[15:0] = s_r.rng_int;
        OFF_ALLOW:    s_nxt.prdata[5:0] = s_r.allow;
        OFF_STATUS: begin
          s_nxt.prdata[1:0]   = s_r.st;
          s_nxt.prdata[2]     = s_r.sched;
          s_nxt.prdata[31:16] = s_r.jump_used;
        end
        OFF_HOLD:     s_nxt.prdata[19:0] = s_r.hold_ms;
        OFF_INT_STAT: s_nxt.prdata[IRQ_W-1:0] = s_r.int_stat;
        OFF_INT_MASK: s_nxt.prdata[IRQ_W-1:0] = s_r.int_mask;
        default:      s_nxt.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{st: HE_IDLE, rng_int: 16'(RNG_INT_RST),
               allow: 6'(ALLOW_RST), crc_ok: 1'b1, default: '0};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign link.req_vld   = s_r.req_vld;
  assign link.req_tech  = s_r.tech;
  assign link.req_hints = s_r.hints;
  assign link.ack_vld   = s_r.ack_vld;
  assign link.he_crc_ok = s_r.crc_ok;
  assign link.sched     = s_r.sched;
  assign prdata         = s_r.prdata;
  assign pready         = s_r.pready;
  assign pslverr        = s_r.pslverr;
  assign resv_held      = s_r.held;
  assign irq            = s_r.irq;
endmodule : cca_headend
`default_nettype wire

// ### tb/cca_chk_sva.sv
// Checker on the link between head-end and modem ends.
// Assumes both ends on clk_sys with active-low asynchronous resetn.
`timescale 1ns/10ps
`default_nettype none
module cca_chk
  import cca_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       req_vld,
  input wire logic [2:0] req_tech,
  input wire logic       he_crc_ok,
  input wire logic       ack_vld,
  input wire logic       sched,
  input wire logic       rsp_vld,
  input wire logic       rsp_arrive,
  input wire logic       rng_req,
  input wire logic       cm_crc_ok
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_maint_sched;
    req_vld && he_crc_ok && req_tech == TECH_MAINT |-> ##[0:2] sched;
  endproperty
  property p_sched_cause;
    $rose(sched) |-> req_vld || $past(req_vld) || $past(req_vld, 2);
  endproperty
  property p_depart;
    req_vld && he_crc_ok && req_tech != TECH_RESET |=> rsp_vld && !rsp_arrive;
  endproperty
  property p_direct_norng;
    req_vld && he_crc_ok && req_tech == TECH_DIRECT |=> !rng_req [*8];
  endproperty
  property p_bad_req;
    req_vld && !he_crc_ok |=> !rsp_vld;
  endproperty
  property p_bad_rsp;
    rsp_vld && rsp_arrive && !cm_crc_ok |=> !ack_vld;
  endproperty
  property p_ack_cause;
    ack_vld |-> $past(cm_crc_ok && (rng_req || rsp_vld && rsp_arrive));
  endproperty
  property p_sched_end;
    ack_vld |=> !sched;
  endproperty
  a_maint_sched: assert property (p_maint_sched)
    else $error("no scheduling after maintenance request");
  a_sched_cause: assert property (p_sched_cause)
    else $error("scheduling without request");
  a_depart: assert property (p_depart)
    else $error("no depart response");
  a_direct_norng: assert property (p_direct_norng)
    else $error("ranging in direct use");
  a_bad_req: assert property (p_bad_req)
    else $error("bad request answered");
  a_bad_rsp: assert property (p_bad_rsp)
    else $error("bad arrival acknowledged");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without arrival");
  a_sched_end: assert property (p_sched_end)
    else $error("scheduling after arrival");
  c_ack: cover property (ack_vld);
  c_rng: cover property (sched && rng_req);
  c_bad: cover property (rsp_vld && !cm_crc_ok);
endmodule : cca_chk
`default_nettype wire

// ### tb/channel_change_arrival_timer_test.sv
// Testbench joining head-end and modem ends over the link.
// Assumes cca_pkg, link interface and both ends compiled first.
`timescale 1ns/10ps
`default_nettype none
module channel_change_arrival_timer_test;
  import cca_pkg::*;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
    logic        er;
  } cca_note_t;
  localparam logic [31:0] M = 32'hFFFF_FFFF;
  logic        clk_sys = 1'h0;
  logic        resetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, resv_held, irq, moving, arrived, slow;
  logic        old_abort = 1'h0;
  logic        jump_en = 1'h0;
  logic        crc_err_inj = 1'h0;
  logic [15:0] jump_ms = 16'h0;
  logic [15:0] seed = 16'h5FC3;
  logic [2:0]  tech_seen;
  int          err_total = 0;
  int          checks = 0;
  cca_note_t   note_q[$];
  cca_note_t   nt;
  always #10 clk_sys = ~clk_sys;
  cca_link_if lk();
  cca_headend #(.MS_CYCLES(5)) cca_headend_inst(.clk_sys, .resetn,
    .ce(1'h1), .link(lk), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .old_abort, .resv_held, .irq);
  cca_modem #(.MS_CYCLES(5)) cca_modem_inst(.clk_sys, .resetn, .ce(1'h1),
    .link(lk), .jump_ms, .jump_en, .crc_err_inj, .moving, .arrived,
    .tech_seen, .slow);
  cca_chk cca_chk_inst(.clk_sys, .resetn, .req_vld(lk.req_vld),
    .req_tech(lk.req_tech), .he_crc_ok(lk.he_crc_ok), .ack_vld(lk.ack_vld),
    .sched(lk.sched), .rsp_vld(lk.rsp_vld), .rsp_arrive(lk.rsp_arrive),
    .rng_req(lk.rng_req), .cm_crc_ok(lk.cm_crc_ok));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic fail(input logic [31:0] got, input logic [31:0] exp);
    err_total++;
    $display("Error t=%0t got %h exp %h", $time, got, exp);
  endtask : fail
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) fail(got, exp);
  endtask : cmp
  // Bus cycle; expected read data noted for the watcher
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] e = 32'h0,
    input logic [31:0] m = 32'h0, input logic er = 1'h0);
    int n;
    note_q.push_back({e, m, er});
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      fail(32'(n), 32'h0);
      final_report();
    end
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask : apb
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'h1) begin
      nt = note_q.pop_front();
      checks++;
      if ((prdata & nt.m) !== nt.e || pslverr !== nt.er) fail(prdata, nt.e);
    end
  end
  // One channel change; f: bit0 bad request, bit1 bad modem CRC, bit2 abort
  task automatic txn(input logic [2:0] t, input logic je,
    input logic [15:0] jm, input logic [15:0] rg, input logic [2:0] f,
    input logic [4:0] ex, input logic [15:0] ej);
    logic [15:0] al;
    int n;
    int h;
    int a;
    seed = lfsr(seed);
    if (rg == 16'h0) rg = {12'h0, seed[3:0]} + 16'h1;
    al = 16'h14 + {11'h0, seed[8:4]} % 16'h15;
    apb(1'h1, OFF_RNG_INT, {16'h0, rg});
    apb(1'h1, OFF_ALLOW, {16'h0, al});
    jump_ms <= jm;
    jump_en <= je;
    crc_err_inj <= f[1];
    apb(1'h1, OFF_CMD, {22'h0, f[0], 1'h1, 1'h0, t, 3'h0, 1'h1});
    apb(1'h0, OFF_CMD, 32'h0, {23'h0, 1'h1, 1'h0, t, 4'h0},
      32'h0000_0170);
    if (t != TECH_RESET) begin
      apb(1'h0, OFF_HOLD, 32'h0);
      h = 2 * rg + al + ((je && f[1:0] == 2'h0) ? jm : DEF_JUMP_MS);
      checks++;
      if (rd > h || rd + 2 < h) fail(rd, h);
    end
    n = 0;
    a = 0;
    while ((resv_held !== 1'h0 || n < 102) && n < 30000) begin
      @(posedge clk_sys);
      n++;
      if (arrived === 1'h1) a++;
      if (f[2] && n == 100) old_abort <= 1'h1;
      if (n == 101) old_abort <= 1'h0;
    end
    if (n >= 30000) begin
      fail(32'(n), 32'h0);
      final_report();
    end
    crc_err_inj <= 1'h0;
    apb(1'h0, OFF_INT_STAT, 32'h0, {27'h0, ex}, 32'h1F);
    apb(1'h1, OFF_INT_MASK, {27'h0, ex});
    repeat (2) @(posedge clk_sys);
    cmp(32'(irq), 32'(ex != 5'h0));
    apb(1'h1, OFF_INT_STAT, {27'h0, ex});
    repeat (2) @(posedge clk_sys);
    cmp(32'(irq), 32'h0);
    n = 0;
    while (moving !== 1'h0 && n < 30000) begin
      @(posedge clk_sys);
      n++;
      if (arrived === 1'h1) a++;
    end
    if (n >= 30000) begin
      fail(32'(n), 32'h0);
      final_report();
    end
    if (t != TECH_RESET) apb(1'h0, OFF_STATUS, 32'h0, {ej, 16'h0}, 32'hFFFF_0003);
    if (!f[0]) cmp(32'(tech_seen), 32'(t));
    cmp(32'(a), 32'(!f[0] && t != TECH_RESET));
    if (!f[0] && t == TECH_DIRECT) cmp(32'(slow), 32'(jm > 16'h3E8));
    $display("change tech %0d done", t);
  endtask : txn
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'h1;
    apb(1'h0, OFF_RNG_INT, 32'h0, 32'h3E8, M);
    apb(1'h0, OFF_ALLOW, 32'h0, 32'h28, M);
    apb(1'h0, OFF_STATUS, 32'h0, 32'h0, M);
    apb(1'h1, 12'h01C, 32'h5, 32'h0, 32'h0, 1'h1);
    apb(1'h0, 12'h01C, 32'h0, 32'h0, 32'h0, 1'h1);
    apb(1'h1, OFF_ALLOW, 32'hA);
    apb(1'h0, OFF_ALLOW, 32'h0, 32'h14, M);
    apb(1'h1, OFF_ALLOW, 32'h50);
    apb(1'h0, OFF_ALLOW, 32'h0, 32'h28, M);
    $display("register test done");
    txn(TECH_DIRECT, 1'h0, 16'h32, 16'h0, 3'h0, 5'h01, 16'h514);
    txn(TECH_DIRECT, 1'h1, 16'h44C, 16'h0, 3'h0, 5'h01, 16'h44C);
    txn(TECH_MAINT, 1'h0, 16'h32, 16'h0, 3'h0, 5'h01, 16'h514);
    txn(TECH_RESET, 1'h0, 16'h32, 16'h0, 3'h4, 5'h00, 16'h0);
    txn(TECH_DIRECT, 1'h1, 16'h3E8, 16'h0, 3'h4, 5'h04, 16'h3E8);
    txn(TECH_DIRECT, 1'h0, 16'h32, 16'h2, 3'h2, 5'h0A, 16'h514);
    txn(TECH_DIRECT, 1'h0, 16'h32, 16'h578, 3'h1, 5'h12, 16'h514);
    final_report();
  end
endmodule : channel_change_arrival_timer_test
`default_nettype wire
